// file: src/ela_pkg.sv
package ela_pkg;
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;
    localparam logic [7:0] IST_OFS = 8'h08;
    localparam logic [7:0] ICLR_OFS = 8'h0C;
    localparam logic [7:0] IEN_OFS = 8'h10;
    localparam logic [7:0] CIDX_OFS = 8'h14;
    localparam logic [7:0] CDAT_OFS = 8'h18;
    localparam logic [7:0] SIDX_OFS = 8'h1C;
    localparam logic [7:0] SDAT_OFS = 8'h20;
    localparam logic [7:0] MIDX_OFS = 8'h24;
    localparam logic [7:0] MDAT_OFS = 8'h28;
    localparam logic [9:0] CTRL_RST = 10'h000;
    localparam logic [1:0] IEN_RST = 2'h0;
    localparam int IRQ_TRIG = 0;
    localparam int IRQ_DONE = 1;
    localparam int NCOND = 3;
    localparam int QUARTERS = 4;
    localparam int J_TCK = 0;
    localparam int J_TDI = 1;
    localparam int J_SEL = 2;
    localparam int J_CAP = 3;
    localparam int J_SHF = 4;
    localparam int J_UPD = 5;
    localparam int JDR_W = 40;
    localparam int MIDX_WORD = 16;

    typedef enum logic [2:0] {ST_IDLE, ST_LOAD, ST_PRE, ST_WAIT, ST_POST, ST_DONE} ela_state_t;

    typedef struct packed {
        logic [2:0] and_mode;
        logic ack;
        logic [1:0] ncond;
        logic [1:0] pre;
        logic rpt;
        logic arm;
    } ela_ctrl_t;

    typedef struct packed {
        logic wr;
        logic [6:0] addr;
        logic [31:0] data;
    } ela_jdr_t;
endpackage : ela_pkg

// file: src/ela_top.sv
// What this block does
// - Monitor width 1..4064, all bits sampled together
// - Depth 512..16384, one sample per clock
// - Separate trigger vector, 1..40 bits wide
// - Up to three conditions met in order
// - Per condition bit subset, AND or OR
// - Per bit rise, fall or level match
// - Host loaded stimuli vector, 0..512 bits
// - Stimuli applied before capture starts
// - Pre-trigger storage in quarter depth steps
// - Build-time trigger arms capture at startup
// - Repetitive mode re-arms when the host acknowledges a capture
// - Samples held in memory until read
// - Settings in, samples out over JTAG
// - JTAG port shared without disturbing others
module ela_top #(
    parameter int MW = 32,
    parameter int DEPTH = 512,
    parameter int TW = 8,
    parameter int SW = 8,
    parameter bit INIT_EN = 1'b0,
    parameter logic [3*TW-1:0] INIT_CFG = '0,
    parameter bit INIT_AND = 1'b0
) (
    input wire logic SYS_CLK_I,
    input wire logic RST_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    output logic IRQ_O,
    input wire logic [MW-1:0] MON_I,
    input wire logic [TW-1:0] TRIG_I,
    output logic [((SW > 0) ? SW : 1)-1:0] STIM_O,
    input wire logic TCK_I,
    input wire logic TDI_I,
    input wire logic JSEL_I,
    input wire logic JCAPTURE_I,
    input wire logic JSHIFT_I,
    input wire logic JUPDATE_I,
    output logic TDO_O,
    output logic TDO_OE_O
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = 3 * TW;
    localparam int CWP = 32 * ((CW + 31) / 32);
    localparam int SWP = (SW > 0) ? SW : 1;
    localparam int SWW = 32 * ((SWP + 31) / 32);
    localparam int MWW = 32 * ((MW + 31) / 32);

    if (MW < 1 || MW > 4064 || DEPTH < 512 || DEPTH > 16384 || (DEPTH & (DEPTH - 1)) != 0
        || TW < 1 || TW > 40 || SW < 0 || SW > 512) begin : g_bad_param
        $error("ela_top: parameter out of range");
    end

    ela_pkg::ela_ctrl_t ctrl_ff, nxt_ctrl;
    logic [1:0] ist_ff, nxt_ist, ien_ff, nxt_ien;
    logic [3:0] cidx_ff, nxt_cidx, sidx_ff, nxt_sidx;
    logic [31:0] midx_ff, nxt_midx;
    logic [CWP-1:0] cfg_ff [ela_pkg::NCOND];
    logic [CWP-1:0] nxt_cfg [ela_pkg::NCOND];
    logic [SWW-1:0] stg_ff, nxt_stg;
    logic rdy_ff, nxt_rdy, perr_ff, nxt_perr, irq_ff, nxt_irq;
    logic [31:0] prd_ff, nxt_prd;
    logic [MW-1:0] mem [DEPTH];
    ela_pkg::ela_state_t state_ff, nxt_state;
    logic [AW-1:0] wp_ff, nxt_wp;
    logic [AW:0] cnt_ff, nxt_cnt, pre_n, post_n;
    logic [1:0] stage_ff, nxt_stage, last_stage;
    logic [TW-1:0] tprv_ff, nxt_tprv;
    logic [SWP-1:0] stim_ff, nxt_stim;
    logic init_ff, nxt_init;
    logic [5:0] js1_ff, js2_ff, js3_ff, jl_ff, nxt_jl;
    ela_pkg::ela_jdr_t jdr_ff, nxt_jdr, jop_ff, nxt_jop;
    logic jpend_ff, nxt_jpend, tdo_ff, nxt_tdo, tdoe_ff, nxt_tdoe;
    logic [31:0] jrd_ff, nxt_jrd;
    logic apb_acc, apb_we, jexe, we, arm_p, ack_p, go, hit, trig_ev, done_ev, cap_wr, tck_rise;
    logic [7:0] wa;
    logic [31:0] wd;
    logic [1:0] clr;

    // Match of one condition against the current and previous trigger sample
    function automatic logic chit(input logic [CWP-1:0] c, input logic andm,
                                  input logic [TW-1:0] cur, input logic [TW-1:0] prv);
        logic [TW-1:0] msk, edg, pol, m;
        msk = c[TW-1:0];
        edg = c[2*TW-1:TW];
        pol = c[3*TW-1:2*TW];
        m = (edg & ((pol & cur & ~prv) | (~pol & ~cur & prv)))
            | (~edg & ~(pol ^ cur));
        chit = andm ? &(m | ~msk) : |(m & msk);
    endfunction : chit

    function automatic logic regok(input logic [7:0] a);
        regok = (a[1:0] == 2'h0) && (a <= ela_pkg::MDAT_OFS);
    endfunction : regok

    function automatic logic [31:0] rd(input logic [7:0] a);
        logic [MWW-1:0] mw;
        logic [15:0] ms;
        logic [6:0] mwd;
        mw = '0;
        ms = midx_ff[15:0];
        mwd = midx_ff[ela_pkg::MIDX_WORD +: 7];
        mw[MW-1:0] = mem[ms[AW-1:0]];
        rd = 32'h0;
        case (a)
            ela_pkg::CTRL_OFS: rd = {22'h0, ctrl_ff};
            ela_pkg::STAT_OFS: rd = {16'(wp_ff), 11'h0, stage_ff, state_ff};
            ela_pkg::IST_OFS: rd = {30'h0, ist_ff};
            ela_pkg::IEN_OFS: rd = {30'h0, ien_ff};
            ela_pkg::CIDX_OFS: rd = {28'h0, cidx_ff};
            ela_pkg::CDAT_OFS: begin
                if (cidx_ff[3:2] < 2'(ela_pkg::NCOND) && 32'(cidx_ff[1:0]) < CWP / 32) begin
                    rd = cfg_ff[cidx_ff[3:2]][32*cidx_ff[1:0] +: 32];
                end
            end
            ela_pkg::SIDX_OFS: rd = {28'h0, sidx_ff};
            ela_pkg::SDAT_OFS: begin
                if (32'(sidx_ff) < SWW / 32) begin
                    rd = stg_ff[32*sidx_ff +: 32];
                end
            end
            ela_pkg::MIDX_OFS: rd = midx_ff;
            ela_pkg::MDAT_OFS: begin
                if (32'(ms) < DEPTH && 32'(mwd) < MWW / 32) begin
                    rd = mw[32*mwd +: 32];
                end
            end
            default: rd = 32'h0;
        endcase
    endfunction : rd

    // Register access: APB has priority, a pending JTAG access waits one cycle
    assign apb_acc = PSEL_I & PENABLE_I & ~rdy_ff;
    assign apb_we = PSEL_I & PENABLE_I & PWRITE_I & rdy_ff & ~perr_ff;
    assign jexe = jpend_ff & ~apb_we;
    assign we = apb_we | (jexe & jop_ff.wr);
    assign wa = apb_we ? PADDR_I[7:0] : {1'b0, jop_ff.addr};
    assign wd = apb_we ? PWDATA_I : jop_ff.data;
    assign arm_p = we && wa == ela_pkg::CTRL_OFS && wd[0];
    assign ack_p = we && wa == ela_pkg::CTRL_OFS && wd[6];

    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_ien = ien_ff;
        nxt_cidx = cidx_ff;
        nxt_sidx = sidx_ff;
        nxt_midx = midx_ff;
        nxt_cfg = cfg_ff;
        nxt_stg = stg_ff;
        clr = 2'h0;
        nxt_rdy = apb_acc;
        nxt_perr = apb_acc & ~(regok(PADDR_I[7:0]) && PADDR_I[11:8] == 4'h0);
        nxt_prd = apb_acc ? (nxt_perr ? 32'h0 : rd(PADDR_I[7:0])) : prd_ff;
        if (we) begin
            case (wa)
                ela_pkg::CTRL_OFS: begin
                    nxt_ctrl = wd[9:0];
                    nxt_ctrl.arm = 1'b0;
                    nxt_ctrl.ack = 1'b0;
                end
                ela_pkg::ICLR_OFS: clr = wd[1:0];
                ela_pkg::IEN_OFS: nxt_ien = wd[1:0];
                ela_pkg::CIDX_OFS: nxt_cidx = wd[3:0];
                ela_pkg::CDAT_OFS: begin
                    if (cidx_ff[3:2] < 2'(ela_pkg::NCOND) && 32'(cidx_ff[1:0]) < CWP / 32) begin
                        nxt_cfg[cidx_ff[3:2]][32*cidx_ff[1:0] +: 32] = wd;
                    end
                end
                ela_pkg::SIDX_OFS: nxt_sidx = wd[3:0];
                ela_pkg::SDAT_OFS: begin
                    if (32'(sidx_ff) < SWW / 32) begin
                        nxt_stg[32*sidx_ff +: 32] = wd;
                    end
                end
                ela_pkg::MIDX_OFS: nxt_midx = wd;
                default: nxt_ctrl = ctrl_ff;
            endcase
        end
        nxt_ist = (ist_ff & ~clr) | {done_ev, trig_ev};
        nxt_irq = |(nxt_ist & nxt_ien);
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            ctrl_ff <= ela_pkg::CTRL_RST;
            ctrl_ff.and_mode[0] <= INIT_AND;
            ien_ff <= ela_pkg::IEN_RST;
            ist_ff <= 2'h0;
            cidx_ff <= 4'h0;
            sidx_ff <= 4'h0;
            midx_ff <= 32'h0;
            cfg_ff <= '{default: '0};
            cfg_ff[0][CW-1:0] <= INIT_CFG;
            stg_ff <= '0;
            rdy_ff <= 1'b0;
            perr_ff <= 1'b0;
            prd_ff <= 32'h0;
            irq_ff <= 1'b0;
        end else begin
            ctrl_ff <= nxt_ctrl;
            ien_ff <= nxt_ien;
            ist_ff <= nxt_ist;
            cidx_ff <= nxt_cidx;
            sidx_ff <= nxt_sidx;
            midx_ff <= nxt_midx;
            cfg_ff <= nxt_cfg;
            stg_ff <= nxt_stg;
            rdy_ff <= nxt_rdy;
            perr_ff <= nxt_perr;
            prd_ff <= nxt_prd;
            irq_ff <= nxt_irq;
        end
    end

    // Capture sequencer
    assign pre_n = (AW+1)'(ctrl_ff.pre) * (AW+1)'(DEPTH / ela_pkg::QUARTERS);
    assign post_n = (AW+1)'(DEPTH) - pre_n;
    assign last_stage = (ctrl_ff.ncond == 2'h0) ? 2'h0 : ctrl_ff.ncond - 2'h1;
    assign hit = chit(cfg_ff[stage_ff], ctrl_ff.and_mode[stage_ff], TRIG_I, tprv_ff);
    assign go = arm_p | init_ff | (ack_p & ctrl_ff.rpt);
    assign cap_wr = state_ff == ela_pkg::ST_PRE || state_ff == ela_pkg::ST_WAIT
                    || state_ff == ela_pkg::ST_POST;

    always_comb begin
        nxt_state = state_ff;
        nxt_wp = wp_ff;
        nxt_cnt = cnt_ff;
        nxt_stage = stage_ff;
        nxt_stim = stim_ff;
        nxt_init = init_ff;
        nxt_tprv = TRIG_I;
        trig_ev = 1'b0;
        done_ev = 1'b0;
        if (cap_wr) begin
            nxt_wp = wp_ff + AW'(1);
        end
        case (state_ff)
            ela_pkg::ST_IDLE, ela_pkg::ST_DONE: begin
                if (go) begin
                    nxt_init = 1'b0;
                    nxt_stim = stg_ff[SWP-1:0];
                    nxt_state = ela_pkg::ST_LOAD;
                end
            end
            ela_pkg::ST_LOAD: begin
                nxt_cnt = '0;
                nxt_stage = 2'h0;
                nxt_state = (pre_n == '0) ? ela_pkg::ST_WAIT : ela_pkg::ST_PRE;
            end
            ela_pkg::ST_PRE: begin
                nxt_cnt = cnt_ff + (AW+1)'(1);
                if (cnt_ff == pre_n - (AW+1)'(1)) begin
                    nxt_state = ela_pkg::ST_WAIT;
                end
            end
            ela_pkg::ST_WAIT: begin
                if (hit) begin
                    if (stage_ff >= last_stage) begin
                        trig_ev = 1'b1;
                        nxt_cnt = (AW+1)'(1);
                        nxt_state = ela_pkg::ST_POST;
                    end else begin
                        nxt_stage = stage_ff + 2'h1;
                    end
                end
            end
            ela_pkg::ST_POST: begin
                nxt_cnt = cnt_ff + (AW+1)'(1);
                if (cnt_ff == post_n - (AW+1)'(1)) begin
                    done_ev = 1'b1;
                    nxt_state = ela_pkg::ST_DONE;
                end
            end
            default: nxt_state = ela_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            state_ff <= ela_pkg::ST_IDLE;
            wp_ff <= '0;
            cnt_ff <= '0;
            stage_ff <= 2'h0;
            tprv_ff <= '0;
            stim_ff <= '0;
            init_ff <= INIT_EN;
        end else begin
            state_ff <= nxt_state;
            wp_ff <= nxt_wp;
            cnt_ff <= nxt_cnt;
            stage_ff <= nxt_stage;
            tprv_ff <= nxt_tprv;
            stim_ff <= nxt_stim;
            init_ff <= nxt_init;
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (cap_wr) begin
            mem[wp_ff] <= MON_I;
        end
    end

    // JTAG user data register, pins sampled by the system clock
    assign tck_rise = ~jl_ff[ela_pkg::J_TCK] & (js2_ff[ela_pkg::J_TCK] == js3_ff[ela_pkg::J_TCK])
                      & js3_ff[ela_pkg::J_TCK];

    always_comb begin
        nxt_jl = jl_ff;
        for (int i = 0; i < 6; i++) begin
            if (js2_ff[i] == js3_ff[i]) begin
                nxt_jl[i] = js3_ff[i];
            end
        end
        nxt_jdr = jdr_ff;
        nxt_jop = jop_ff;
        nxt_jpend = jpend_ff & ~jexe;
        nxt_jrd = (jexe & ~jop_ff.wr) ? rd({1'b0, jop_ff.addr}) : jrd_ff;
        if (tck_rise && jl_ff[ela_pkg::J_SEL]) begin
            if (jl_ff[ela_pkg::J_CAP]) begin
                nxt_jdr = {8'h00, jrd_ff};
            end else if (jl_ff[ela_pkg::J_SHF]) begin
                nxt_jdr = {jl_ff[ela_pkg::J_TDI], jdr_ff[ela_pkg::JDR_W-1:1]};
            end else if (jl_ff[ela_pkg::J_UPD]) begin
                nxt_jop = jdr_ff;
                nxt_jpend = 1'b1;
            end
        end
        nxt_tdo = nxt_jdr[0];
        nxt_tdoe = nxt_jl[ela_pkg::J_SEL] & nxt_jl[ela_pkg::J_SHF];
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            js1_ff <= 6'h00;
            js2_ff <= 6'h00;
            js3_ff <= 6'h00;
            jl_ff <= 6'h00;
            jdr_ff <= '0;
            jop_ff <= '0;
            jpend_ff <= 1'b0;
            jrd_ff <= 32'h0;
            tdo_ff <= 1'b0;
            tdoe_ff <= 1'b0;
        end else begin
            js1_ff <= {JUPDATE_I, JSHIFT_I, JCAPTURE_I, JSEL_I, TDI_I, TCK_I};
            js2_ff <= js1_ff;
            js3_ff <= js2_ff;
            jl_ff <= nxt_jl;
            jdr_ff <= nxt_jdr;
            jop_ff <= nxt_jop;
            jpend_ff <= nxt_jpend;
            jrd_ff <= nxt_jrd;
            tdo_ff <= nxt_tdo;
            tdoe_ff <= nxt_tdoe;
        end
    end

    assign PRDATA_O = prd_ff;
    assign PREADY_O = rdy_ff;
    assign PSLVERR_O = perr_ff;
    assign IRQ_O = irq_ff;
    assign STIM_O = stim_ff;
    assign TDO_O = tdo_ff;
    assign TDO_OE_O = tdoe_ff;
endmodule : ela_top

// file: testbench/ela_props.sv
module ela_props #(
    parameter int SW = 8
) (
    input wire logic SYS_CLK_I,
    input wire logic RST_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PRDATA_O,
    input wire logic PREADY_O,
    input wire logic PSLVERR_O,
    input wire logic IRQ_O,
    input wire logic [((SW > 0) ? SW : 1)-1:0] STIM_O,
    input wire logic JSEL_I,
    input wire logic TDO_OE_O
);
    timeunit 1ns;
    timeprecision 100ps;

    default clocking cb @(posedge SYS_CLK_I);
    endclocking
    default disable iff (RST_I);

    ready_wait_a: assert property (PSEL_I && PENABLE_I && !PREADY_O |=> PREADY_O)
        else $error("access phase not answered after one wait state");
    ready_pulse_a: assert property (PREADY_O |=> !PREADY_O)
        else $error("ready held longer than one cycle");
    ready_cause_a: assert property (PREADY_O |-> $past(PSEL_I && PENABLE_I) && $past(PSEL_I, 2))
        else $error("ready without a setup and access phase");
    err_with_ready_a: assert property (PSLVERR_O |-> PREADY_O)
        else $error("error flag outside a ready cycle");
    err_decode_a: assert property (PREADY_O && PADDR_I[11:8] != 4'h0 |-> PSLVERR_O)
        else $error("out of range address not refused");
    rdata_hold_a: assert property (!PREADY_O |-> $stable(PRDATA_O))
        else $error("read data changed outside an answer");
    oe_idle_a: assert property (!JSEL_I [*6] |-> !TDO_OE_O)
        else $error("data out driven while the port is not selected");
    reset_quiet_a: assert property ($past(RST_I) |-> !IRQ_O && !PREADY_O && STIM_O == '0)
        else $error("outputs not quiet after reset");
endmodule : ela_props

bind ela_top ela_props #(.SW(SW)) ela_props_inst (
    .SYS_CLK_I(SYS_CLK_I), .RST_I(RST_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PADDR_I(PADDR_I),
    .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .IRQ_O(IRQ_O), .STIM_O(STIM_O),
    .JSEL_I(JSEL_I), .TDO_OE_O(TDO_OE_O));

// file: testbench/ela_jtag_host.sv
module ela_jtag_host (
    output logic tck_o,
    output logic tdi_o,
    output logic jsel_o,
    output logic jcap_o,
    output logic jshf_o,
    output logic jupd_o,
    input wire logic tdo_i
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        tck_o = 1'b0;
        tdi_o = 1'b0;
        jsel_o = 1'b0;
        jcap_o = 1'b0;
        jshf_o = 1'b0;
        jupd_o = 1'b0;
    end

    // Link clock only runs inside a frame, at 125 ns period
    task automatic pulse();
        #62.5 tck_o = 1'b1;
        #62.5 tck_o = 1'b0;
    endtask : pulse

    // One 40-bit operation, LSB first; returns the word captured at its start
    task automatic op(input logic [39:0] w, output logic [39:0] q);
        // Start off the system clock edge so no pin moves on it
        #0.3;
        jsel_o = 1'b1;
        jcap_o = 1'b1;
        pulse();
        jcap_o = 1'b0;
        jshf_o = 1'b1;
        for (int i = 0; i < 40; i++) begin
            tdi_o = w[i];
            #62.5 q[i] = tdo_i;
            tck_o = 1'b1;
            #62.5 tck_o = 1'b0;
        end
        jshf_o = 1'b0;
        tdi_o = ~tdi_o;
        jupd_o = 1'b1;
        pulse();
        jupd_o = 1'b0;
        jsel_o = 1'b0;
        #500;
    endtask : op
endmodule : ela_jtag_host

// file: testbench/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [11:0] pa = 12'h000;
    logic [31:0] pwd = 32'h0;
    logic [31:0] mon = 32'h0;
    logic [7:0] trig = 8'h00;
    logic [31:0] prd, r, tm;
    logic [7:0] stim;
    logic prdy, perr, irq, tck, tdi, jsel, jcap, jshf, jupd, tdo, tdo_oe, e;
    logic [39:0] q;
    int num_errors = 0;
    int checks_done = 0;

    ela_top #(.MW(32), .DEPTH(512), .TW(8), .SW(8)) ela_top_inst (
        .SYS_CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(pa),
        .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(prdy), .PSLVERR_O(perr), .IRQ_O(irq), .MON_I(mon),
        .TRIG_I(trig), .STIM_O(stim), .TCK_I(tck), .TDI_I(tdi), .JSEL_I(jsel), .JCAPTURE_I(jcap),
        .JSHIFT_I(jshf), .JUPDATE_I(jupd), .TDO_O(tdo), .TDO_OE_O(tdo_oe));
    ela_jtag_host ela_jtag_host_inst (.tck_o(tck), .tdi_o(tdi), .jsel_o(jsel), .jcap_o(jcap),
        .jshf_o(jshf), .jupd_o(jupd), .tdo_i(tdo));

    initial begin
        forever #4 clk = ~clk;
    end
    always @(posedge clk) mon <= mon + 32'h1;

    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        checks_done++;
        if (g !== x) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", n, x, g);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (prdy !== 1'b1) @(posedge clk);
        r = prd;
        e = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, {4'h0, a}, d);
    endtask : wr

    task automatic rd(input logic [7:0] a);
        apb(1'b0, {4'h0, a}, 32'h0);
    endtask : rd

    task automatic wait_st(input logic [2:0] s);
        for (int i = 0; i < 400; i++) begin
            rd(ela_pkg::STAT_OFS);
            if (r[2:0] === s) break;
        end
        chk("state", {29'h0, s}, {29'h0, r[2:0]});
    endtask : wait_st

    task automatic set_trig(input logic [7:0] v);
        @(posedge clk);
        trig <= v;
        tm = mon + 32'h1;
    endtask : set_trig

    task automatic mem_at(input logic [8:0] s, input logic [31:0] x);
        wr(ela_pkg::MIDX_OFS, {23'h0, s});
        rd(ela_pkg::MDAT_OFS);
        chk("sample", x, r);
    endtask : mem_at

    task automatic mem_chk(input logic [31:0] pn);
        logic [8:0] wp;
        rd(ela_pkg::STAT_OFS);
        wp = r[24:16];
        mem_at(wp, tm - pn);
        mem_at(wp + pn[8:0], tm);
        mem_at(wp + 9'h1FF, tm - pn + 32'h1FF);
    endtask : mem_chk

    task automatic t_regs();
        rd(ela_pkg::CTRL_OFS);
        chk("ctrl", 32'h0, r);
        rd(ela_pkg::IEN_OFS);
        chk("irq enable", 32'h0, r);
        apb(1'b0, 12'h100, 32'h0);
        chk("unmapped read", 32'h1, {31'h0, e});
        chk("unmapped data", 32'h0, r);
        apb(1'b1, 12'h02A, 32'h3);
        chk("misaligned write", 32'h1, {31'h0, e});
        $display("test regs done");
    endtask : t_regs

    task automatic t_jtag();
        ela_jtag_host_inst.op({1'b1, 7'h10, 32'h2}, q);
        rd(ela_pkg::IEN_OFS);
        chk("jtag write", 32'h2, r);
        apb(1'b0, 12'h110, 32'h0);
        chk("unmapped data", 32'h0, r);
        ela_jtag_host_inst.op({1'b0, 7'h10, 32'h0}, q);
        ela_jtag_host_inst.op({1'b0, 7'h10, 32'h0}, q);
        chk("jtag read", 32'h2, q[31:0]);
        chk("jtag pad", 32'h0, {24'h0, q[39:32]});
        $display("test jtag done");
    endtask : t_jtag

    task automatic t_cap_pre();
        wr(ela_pkg::IEN_OFS, 32'h3);
        wr(ela_pkg::CIDX_OFS, 32'h0);
        wr(ela_pkg::CDAT_OFS, 32'h010101);
        wr(ela_pkg::SIDX_OFS, 32'h0);
        wr(ela_pkg::SDAT_OFS, 32'hA5);
        chk("stim staged", 32'h0, {24'h0, stim});
        wr(ela_pkg::CTRL_OFS, 32'h5);
        wait_st(3'h3);
        chk("stim applied", 32'hA5, {24'h0, stim});
        set_trig(8'h01);
        wait_st(3'h5);
        chk("irq", 32'h1, {31'h0, irq});
        rd(ela_pkg::IST_OFS);
        chk("irq status", 32'h3, r);
        mem_chk(32'd128);
        wr(ela_pkg::IEN_OFS, 32'h0);
        rd(ela_pkg::IST_OFS);
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(ela_pkg::ICLR_OFS, 32'h3);
        rd(ela_pkg::IST_OFS);
        chk("irq cleared", 32'h0, r);
        $display("test capture with pre-store done");
    endtask : t_cap_pre

    task automatic t_cap_seq();
        wr(ela_pkg::CIDX_OFS, 32'h0);
        wr(ela_pkg::CDAT_OFS, 32'h020002);
        wr(ela_pkg::CIDX_OFS, 32'h4);
        wr(ela_pkg::CDAT_OFS, 32'h000101);
        wr(ela_pkg::SDAT_OFS, 32'h5A);
        wr(ela_pkg::CTRL_OFS, 32'h23);
        wait_st(3'h3);
        chk("stim applied", 32'h5A, {24'h0, stim});
        set_trig(8'h01);
        set_trig(8'h00);
        wait_st(3'h3);
        set_trig(8'h02);
        set_trig(8'h03);
        set_trig(8'h02);
        wait_st(3'h5);
        mem_chk(32'h0);
        set_trig(8'h00);
        wr(ela_pkg::CIDX_OFS, 32'h0);
        wr(ela_pkg::CDAT_OFS, 32'h030003);
        wr(ela_pkg::CTRL_OFS, 32'hC2);
        wait_st(3'h3);
        set_trig(8'h02);
        wait_st(3'h3);
        set_trig(8'h03);
        wait_st(3'h5);
        $display("test sequential trigger done");
    endtask : t_cap_seq

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        #200000;
        num_errors++;
        report_and_stop();
    end

    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_jtag();
        t_cap_pre();
        t_cap_seq();
        report_and_stop();
    end
endmodule : tb
